// file: design/rct_reset_cause.sv
// Reset cause recorder and reset time-out sequencer with APB registers
`timescale 1ns/1ns
`include "rct_cfg.svh"

module rct_reset_cause
  import rct_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_CYCLES  = `RCT_POWERUP_TIMER_MS * `RCT_CLK_MHZ * 1000,
  parameter int unsigned OST_PERIODS  = `RCT_OST_PERIODS,
  parameter bit          HAS_BOR_FLAG = 1'b1,
  parameter bit          HAS_POR_FLAG = 1'b1
)
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire rct_apb_req_t           apb_req_i,
  output rct_apb_rsp_t                apb_rsp_o,
  input  wire logic                   master_clear_pin_n_i,
  input  wire logic                   brownout_det_i,
  input  wire logic                   osc_clk_i,
  input  wire logic [1:0]             osc_mode_i,
  input  wire logic                   powerup_timer_disable_n_i,
  input  wire logic                   brownout_detect_enable_i,
  input  wire logic                   watchdog_timeout_i,
  input  wire logic                   irq_wake_i,
  input  wire logic [7:0]             irq_flags_i,
  input  wire logic                   global_irq_enable_i,
  input  wire logic                   sleep_enter_i,
  input  wire logic [`RCT_PC_W-1:0]   pc_i,
  output logic                        core_reset_o,
  output logic                        pc_load_o,
  output logic [`RCT_PC_W-1:0]        pc_value_o,
  output logic [7:0]                  status_o,
  output logic [7:0]                  option_o,
  output logic [7:0]                  port_dir_o,
  output logic [7:0]                  irq_ctrl_o,
  output logic                        irq_o
);

  // -------------------------------------------------------------
  // Parameter checks
  // -------------------------------------------------------------
  if (POWERUP_TIMER_CYCLES < 1 || POWERUP_TIMER_CYCLES >= (1 << `RCT_CNT_W))
    $error("POWERUP_TIMER_CYCLES does not fit the time-out counter");
  if (OST_PERIODS < 1 || OST_PERIODS >= (1 << `RCT_CNT_W))
    $error("OST_PERIODS does not fit the time-out counter");

  localparam logic [`RCT_CNT_W-1:0] POWERUP_TIMER_LAST = `RCT_CNT_W'(POWERUP_TIMER_CYCLES - 1);
  localparam logic [`RCT_CNT_W-1:0] OST_LAST  = `RCT_CNT_W'(OST_PERIODS - 1);
  localparam logic [1:0]            PRS_IMPL  = {HAS_POR_FLAG, HAS_BOR_FLAG};

  rct_state_t s_r;
  rct_state_t s_nxt;

  logic                  apb_acc;
  logic                  apb_wr;
  logic                  master_clear_pin_low;
  logic                  bor_act;
  logic                  osc_edge;
  logic                  crystal;
  logic                  powerup_timer_on;
  logic                  in_run;
  logic                  wake;
  logic [`RCT_EVT_W-1:0] ev;
  logic [`RCT_EVT_W-1:0] w1c;
  logic [7:0]            wdat;

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb
  begin
    s_nxt    = s_r;
    ev       = '0;
    w1c      = '0;
    wake     = 1'b0;
    wdat     = apb_req_i.pwdata[7:0];
    apb_acc  = apb_req_i.psel & apb_req_i.penable;
    apb_wr   = apb_acc & s_r.rsp.pready & apb_req_i.pwrite;

    // Clear and brown-out pins pass two flops, only the second looked at; the oscillator passes three for edges
    s_nxt.master_clear_pin_s1    = master_clear_pin_n_i;
    s_nxt.master_clear_pin_s2    = s_r.master_clear_pin_s1;
    s_nxt.bor_s1     = brownout_det_i;
    s_nxt.bor_s2     = s_r.bor_s1;
    s_nxt.osc_s1     = osc_clk_i;
    s_nxt.osc_s2     = s_r.osc_s1;
    s_nxt.osc_s3     = s_r.osc_s2;
    master_clear_pin_low         = ~s_r.master_clear_pin_s2;
    bor_act          = brownout_detect_enable_i & s_r.bor_s2;
    osc_edge         = s_r.osc_s2 & ~s_r.osc_s3;
    s_nxt.master_clear_pin_low_d = master_clear_pin_low;
    crystal          = (osc_mode_i != `RCT_OSC_RC);
    powerup_timer_on          = ~powerup_timer_disable_n_i | brownout_detect_enable_i;
    in_run           = (s_r.seq == ST_RUN);

    // APB: one wait state, read data captured with pready
    s_nxt.rsp.pready  = apb_acc & ~s_r.rsp.pready;
    s_nxt.rsp.pslverr = 1'b0;
    s_nxt.rsp.prdata  = '0;
    if (s_nxt.rsp.pready)
    begin
      unique case (apb_req_i.paddr)
        `RCT_OFF_PRS:     s_nxt.rsp.prdata[1:0] = s_r.prs & PRS_IMPL;
        `RCT_OFF_STATUS:  s_nxt.rsp.prdata[7:0] = s_r.status;
        `RCT_OFF_OPTION:  s_nxt.rsp.prdata[7:0] = s_r.option;
        `RCT_OFF_PORTDIR: s_nxt.rsp.prdata[7:0] = s_r.port_dir;
        `RCT_OFF_IRQCTL:  s_nxt.rsp.prdata[7:0] = s_r.irq_ctrl;
        `RCT_OFF_EVT:     s_nxt.rsp.prdata[`RCT_EVT_W-1:0] = s_r.evt;
        `RCT_OFF_MASK:    s_nxt.rsp.prdata[`RCT_EVT_W-1:0] = s_r.mask;
        `RCT_OFF_SEQ:     s_nxt.rsp.prdata[3:0] = {s_r.hold, s_r.seq};
        default:          s_nxt.rsp.pslverr = 1'b1;
      endcase
    end

    // Software writes; hardware events below override them
    if (apb_wr)
    begin
      unique case (apb_req_i.paddr)
        `RCT_OFF_PRS:     s_nxt.prs = wdat[1:0] & PRS_IMPL;
        `RCT_OFF_STATUS:  s_nxt.status = (wdat & `RCT_ST_SW_MASK)
                                       | (s_r.status & ~`RCT_ST_SW_MASK);
        `RCT_OFF_OPTION:  s_nxt.option = wdat;
        `RCT_OFF_PORTDIR: s_nxt.port_dir = wdat;
        `RCT_OFF_IRQCTL:  s_nxt.irq_ctrl = wdat;
        `RCT_OFF_EVT:     w1c = wdat[`RCT_EVT_W-1:0];
        `RCT_OFF_MASK:    s_nxt.mask = wdat[`RCT_EVT_W-1:0];
        default:          ;
      endcase
    end

    // Time-out sequencer
    unique case (s_r.seq)
      ST_POR:
      begin
        s_nxt.cnt       = '0;
        s_nxt.ost_after = crystal;
        if (powerup_timer_on)
          s_nxt.seq = ST_POWERUP_TIMER;
        else if (crystal)
          s_nxt.seq = ST_OST;
        else
          s_nxt.seq = ST_RUN;
      end
      ST_BOR:
      begin
        s_nxt.cnt = '0;
        if (!bor_act)
          s_nxt.seq = ST_POWERUP_TIMER;
      end
      ST_POWERUP_TIMER:
      begin
        if (s_r.cnt == POWERUP_TIMER_LAST)
        begin
          s_nxt.cnt = '0;
          s_nxt.seq = s_r.ost_after ? ST_OST : ST_RUN;
        end
        else
          s_nxt.cnt = s_r.cnt + 1'b1;
      end
      ST_OST:
      begin
        // Counts oscillator edges, not system clocks
        if (osc_edge)
        begin
          if (s_r.cnt == OST_LAST)
            s_nxt.seq = ST_RUN;
          else
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ST_WDT:  s_nxt.seq = ST_RUN;
      ST_RUN:  ;
    endcase

    // Reset and wake events, brown-out first
    if (bor_act && s_r.seq != ST_BOR)
    begin
      // Also restarts a power-up delay that was cut short
      s_nxt.seq          = ST_BOR;
      s_nxt.ost_after    = crystal;
      s_nxt.prs[`RCT_PRS_BOR] = 1'b0;
      s_nxt.status       = (s_r.status & `RCT_ST_LOW_MASK) | `RCT_ST_BOR_SET;
      s_nxt.option       = `RCT_OPTION_RST;
      s_nxt.port_dir     = `RCT_PORTDIR_RST;
      s_nxt.irq_ctrl     = (s_r.irq_ctrl & `RCT_IRQCTL_KEEP) | `RCT_IRQCTL_RST;
      s_nxt.pc_target    = `RCT_PC_RESET;
      s_nxt.pc_pend      = 1'b1;
      s_nxt.sleeping     = 1'b0;
      ev[`RCT_EVT_BOR]   = 1'b1;
    end
    else if (master_clear_pin_low && !s_r.master_clear_pin_low_d && in_run)
    begin
      if (s_r.sleeping)
        s_nxt.status = (s_r.status & `RCT_ST_LOW_MASK) | `RCT_ST_MASTER_CLEAR_PIN_SLP;
      else
        s_nxt.status = s_r.status & `RCT_ST_KEEP5_MASK;
      s_nxt.option       = `RCT_OPTION_RST;
      s_nxt.port_dir     = `RCT_PORTDIR_RST;
      s_nxt.irq_ctrl     = (s_r.irq_ctrl & `RCT_IRQCTL_KEEP) | `RCT_IRQCTL_RST;
      s_nxt.pc_target    = `RCT_PC_RESET;
      s_nxt.pc_pend      = 1'b1;
      s_nxt.sleeping     = 1'b0;
      ev[`RCT_EVT_MASTER_CLEAR_PIN]  = 1'b1;
    end
    else if (watchdog_timeout_i && in_run)
    begin
      if (s_r.sleeping)
      begin
        s_nxt.status = s_r.status & ~(8'h01 << `RCT_ST_TO) & ~(8'h01 << `RCT_ST_PD);
        s_nxt.pc_target        = pc_i + `RCT_PC_STEP;
        wake                   = 1'b1;
        ev[`RCT_EVT_WDT_WAKE]  = 1'b1;
      end
      else
      begin
        s_nxt.seq              = ST_WDT;
        s_nxt.status           = (s_r.status & `RCT_ST_LOW_MASK) | `RCT_ST_WDT_SET;
        s_nxt.option           = `RCT_OPTION_RST;
        s_nxt.port_dir         = `RCT_PORTDIR_RST;
        s_nxt.irq_ctrl         = (s_r.irq_ctrl & `RCT_IRQCTL_KEEP) | `RCT_IRQCTL_RST;
        s_nxt.pc_target        = `RCT_PC_RESET;
        ev[`RCT_EVT_WDT_RST]   = 1'b1;
      end
      s_nxt.pc_pend  = 1'b1;
      s_nxt.sleeping = 1'b0;
    end
    else if (irq_wake_i && s_r.sleeping && in_run)
    begin
      s_nxt.status = (s_r.status & ~(8'h01 << `RCT_ST_PD)) | (8'h01 << `RCT_ST_TO);
      s_nxt.pc_target = global_irq_enable_i ? `RCT_PC_IRQ_VEC : pc_i + `RCT_PC_STEP;
      s_nxt.pc_pend         = 1'b1;
      s_nxt.sleeping        = 1'b0;
      wake                  = 1'b1;
      ev[`RCT_EVT_IRQ_WAKE] = 1'b1;
    end
    else if (sleep_enter_i && in_run && !s_r.sleeping)
    begin
      // Entering sleep marks power-down and sets time-out
      s_nxt.sleeping = 1'b1;
      s_nxt.status   = (s_r.status & ~(8'h01 << `RCT_ST_PD)) | (8'h01 << `RCT_ST_TO);
    end

    // Wakes keep registers but take the waking irq flags
    if (wake)
    begin
      s_nxt.irq_ctrl = s_r.irq_ctrl | (irq_flags_i & `RCT_IRQCTL_FLAGS);
      s_nxt.cnt      = '0;
      if (crystal)
        s_nxt.seq = ST_OST;
    end

    // Core held while sequencing or while the pin is low
    s_nxt.hold    = (s_nxt.seq != ST_RUN) | master_clear_pin_low;
    s_nxt.pc_load = s_nxt.pc_pend & ~s_nxt.hold;
    if (s_nxt.pc_load)
      s_nxt.pc_pend = 1'b0;

    // Sticky events: a new event beats a clear in the same cycle
    s_nxt.evt = (s_r.evt & ~w1c) | ev;
    s_nxt.irq = |(s_nxt.evt & s_nxt.mask);
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      // Power-on: flags cleared, time-out and power-down set
      s_r            <= '0;
      s_r.seq        <= ST_POR;
      s_r.master_clear_pin_s1    <= 1'b1;
      s_r.master_clear_pin_s2    <= 1'b1;
      s_r.hold       <= 1'b1;
      s_r.pc_pend    <= 1'b1;
      s_r.pc_target  <= `RCT_PC_RESET;
      s_r.prs        <= '0;
      s_r.status     <= `RCT_ST_POR;
      s_r.option     <= `RCT_OPTION_RST;
      s_r.port_dir   <= `RCT_PORTDIR_RST;
      s_r.irq_ctrl   <= `RCT_IRQCTL_RST;
      s_r.evt        <= `RCT_EVT_RST;
    end
    else
      s_r <= s_nxt;
  end

  // -------------------------------------------------------------
  // Outputs, all straight from the state register
  // -------------------------------------------------------------
  assign apb_rsp_o    = s_r.rsp;
  assign core_reset_o = s_r.hold;
  assign pc_load_o    = s_r.pc_load;
  assign pc_value_o   = s_r.pc_target;
  assign status_o     = s_r.status;
  assign option_o     = s_r.option;
  assign port_dir_o   = s_r.port_dir;
  assign irq_ctrl_o   = s_r.irq_ctrl;
  assign irq_o        = s_r.irq;

endmodule

// file: design/rct_cfg.svh
// Constants of the reset cause and time-out sequencer
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// -------------------------------------------------------------
// Timing
// -------------------------------------------------------------
`define RCT_CLK_MHZ        250
`define RCT_POWERUP_TIMER_MS        72
`define RCT_OST_PERIODS    1024
`define RCT_CNT_W          25

// -------------------------------------------------------------
// Program counter
// -------------------------------------------------------------
`define RCT_PC_W           13
`define RCT_PC_RESET       13'h0000
`define RCT_PC_IRQ_VEC     13'h0004
`define RCT_PC_STEP        13'h0001

// -------------------------------------------------------------
// Register offsets (byte addresses)
// -------------------------------------------------------------
`define RCT_ADDR_W         8
`define RCT_OFF_PRS        8'h00
`define RCT_OFF_STATUS     8'h04
`define RCT_OFF_OPTION     8'h08
`define RCT_OFF_PORTDIR    8'h0c
`define RCT_OFF_IRQCTL     8'h10
`define RCT_OFF_EVT        8'h14
`define RCT_OFF_MASK       8'h18
`define RCT_OFF_SEQ        8'h1c

// -------------------------------------------------------------
// Field positions, masks and reset patterns
// -------------------------------------------------------------
`define RCT_PRS_BOR        0
`define RCT_PRS_POR        1
`define RCT_ST_TO          4
`define RCT_ST_PD          3
`define RCT_ST_LOW_MASK    8'h07
`define RCT_ST_KEEP5_MASK  8'h1f
`define RCT_ST_SW_MASK     8'he7
`define RCT_ST_POR         8'h18
`define RCT_ST_BOR_SET     8'h18
`define RCT_ST_MASTER_CLEAR_PIN_SLP    8'h10
`define RCT_ST_WDT_SET     8'h08
`define RCT_OPTION_RST     8'hff
`define RCT_PORTDIR_RST    8'hff
`define RCT_IRQCTL_RST     8'h00
`define RCT_IRQCTL_KEEP    8'h01
`define RCT_IRQCTL_FLAGS   8'h07
`define RCT_EVT_W          6
`define RCT_EVT_POR        0
`define RCT_EVT_BOR        1
`define RCT_EVT_MASTER_CLEAR_PIN       2
`define RCT_EVT_WDT_RST    3
`define RCT_EVT_WDT_WAKE   4
`define RCT_EVT_IRQ_WAKE   5
`define RCT_EVT_RST        6'h01
`define RCT_OSC_RC         2'b11

`endif

// file: design/rct_pkg.sv
// Types of the reset cause and time-out sequencer
`include "rct_cfg.svh"
package rct_pkg;

  typedef enum logic [2:0] {ST_POR, ST_BOR, ST_POWERUP_TIMER, ST_OST, ST_WDT, ST_RUN} rct_seq_t;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`RCT_ADDR_W-1:0]  paddr;
    logic [31:0]             pwdata;
  } rct_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rct_apb_rsp_t;

  typedef struct packed {
    rct_seq_t               seq;
    logic [`RCT_CNT_W-1:0]  cnt;
    logic                   master_clear_pin_s1;
    logic                   master_clear_pin_s2;
    logic                   master_clear_pin_low_d;
    logic                   bor_s1;
    logic                   bor_s2;
    logic                   osc_s1;
    logic                   osc_s2;
    logic                   osc_s3;
    logic                   sleeping;
    logic                   ost_after;
    logic                   hold;
    logic                   pc_pend;
    logic                   pc_load;
    logic [`RCT_PC_W-1:0]   pc_target;
    logic [1:0]             prs;
    logic [7:0]             status;
    logic [7:0]             option;
    logic [7:0]             port_dir;
    logic [7:0]             irq_ctrl;
    logic [`RCT_EVT_W-1:0]  evt;
    logic [`RCT_EVT_W-1:0]  mask;
    logic                   irq;
    rct_apb_rsp_t           rsp;
  } rct_state_t;

endpackage

// file: testbench/rct_reset_cause_checker.sv
// Port-level assertions for the reset cause and time-out sequencer
`timescale 1ns/1ns
`include "rct_cfg.svh"
module rct_checker
  import rct_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_CYCLES = `RCT_POWERUP_TIMER_MS * `RCT_CLK_MHZ * 1000
)
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire rct_apb_req_t          apb_req_i,
  input wire rct_apb_rsp_t          apb_rsp_o,
  input wire logic                  master_clear_pin_n_i,
  input wire logic                  brownout_det_i,
  input wire logic [1:0]            osc_mode_i,
  input wire logic                  powerup_timer_disable_n_i,
  input wire logic                  brownout_detect_enable_i,
  input wire logic                  watchdog_timeout_i,
  input wire logic                  irq_wake_i,
  input wire logic                  global_irq_enable_i,
  input wire logic                  sleep_enter_i,
  input wire logic [`RCT_PC_W-1:0]  pc_i,
  input wire logic                  core_reset_o,
  input wire logic                  pc_load_o,
  input wire logic [`RCT_PC_W-1:0]  pc_value_o,
  input wire logic [7:0]            status_o
);
  logic        slp_r;
  logic        first_r;
  logic [31:0] hold_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Shadow of sleep and of the hold length; approximate, so only simple traffic is judged
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      slp_r   <= 1'b0;
      first_r <= 1'b1;
      hold_r  <= 32'h00000000;
    end
    else
    begin
      if (sleep_enter_i && !core_reset_o)
        slp_r <= 1'b1;
      else if (watchdog_timeout_i || irq_wake_i || !master_clear_pin_n_i || brownout_det_i)
        slp_r <= 1'b0;
      if (!core_reset_o)
        first_r <= 1'b0;
      // Wide enough for the full-length power-up delay
      hold_r <= core_reset_o ? hold_r + 32'h00000001 : 32'h00000000;
    end
  end

  // Bus timing, reset, wake and delay checks
  property p_apb_wait;
    apb_req_i.psel && !apb_req_i.penable |=> !apb_rsp_o.pready ##1 apb_rsp_o.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not in second access cycle");
  property p_hi_zero;
    apb_rsp_o.pready |-> apb_rsp_o.prdata[31:8] == 24'h000000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("unused read bits not zero");
  property p_release_load;
    $fell(core_reset_o) |-> pc_load_o;
  endproperty
  a_release_load: assert property (p_release_load) else $error("release without pc load");
  property p_dog_reset;
    watchdog_timeout_i && !core_reset_o && !slp_r && master_clear_pin_n_i && !brownout_det_i
      |=> core_reset_o && status_o == (($past(status_o) & 8'h07) | 8'h08)
      ##1 pc_load_o && pc_value_o == 13'h0000;
  endproperty
  a_dog_reset: assert property (p_dog_reset) else $error("watchdog reset wrong");
  property p_dog_wake;
    slp_r && watchdog_timeout_i |=> status_o[4:3] == 2'b00;
  endproperty
  a_dog_wake: assert property (p_dog_wake) else $error("watchdog wake flags wrong");
  property p_irq_wake;
    slp_r && irq_wake_i && osc_mode_i == 2'b11 |=> pc_load_o && status_o[4:3] == 2'b10
      && pc_value_o == ($past(global_irq_enable_i) ? 13'h0004 : $past(pc_i) + 13'h0001);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake target wrong");
  property p_powerup_timer_min;
    $fell(core_reset_o) && first_r && (!powerup_timer_disable_n_i || brownout_detect_enable_i)
      |-> hold_r >= POWERUP_TIMER_CYCLES;
  endproperty
  a_powerup_timer_min: assert property (p_powerup_timer_min) else $error("power-up delay too short");
  property p_nodelay;
    $rose(rst_n_i) && osc_mode_i == 2'b11 && powerup_timer_disable_n_i
      && !brownout_detect_enable_i |-> ##[1:8] !core_reset_o;
  endproperty
  a_nodelay: assert property (p_nodelay) else $error("delay applied without timer");

  // Main scenarios reached
  c_dog: cover property (watchdog_timeout_i && !core_reset_o && !slp_r);
  c_wake: cover property (slp_r && irq_wake_i);
  c_rel: cover property ($fell(core_reset_o));
endmodule

bind rct_reset_cause rct_checker #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .master_clear_pin_n_i(master_clear_pin_n_i), .brownout_det_i(brownout_det_i),
  .osc_mode_i(osc_mode_i), .powerup_timer_disable_n_i(powerup_timer_disable_n_i),
  .brownout_detect_enable_i(brownout_detect_enable_i), .irq_wake_i(irq_wake_i),
  .watchdog_timeout_i(watchdog_timeout_i), .global_irq_enable_i(global_irq_enable_i),
  .sleep_enter_i(sleep_enter_i), .pc_i(pc_i), .core_reset_o(core_reset_o),
  .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .status_o(status_o)
);

// file: testbench/tb_reset_cause_and_timeout.sv
// Self-checking bench for the reset cause and time-out sequencer
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("BAD %0t got %0h want %0h", $time, a, b); \
    end \
  end
module tb_reset_cause_and_timeout
  import rct_pkg::*;
;
  localparam int PW = 20;
  localparam int OS = 8;
  logic         clk      = 1'b0;
  logic         rst_n    = 1'b0;
  rct_apb_req_t req      = '0;
  rct_apb_rsp_t rsp;
  logic         clr_n    = 1'b1;
  logic         bod      = 1'b0;
  logic         osc      = 1'b0;
  logic [1:0]   mode     = 2'b01;
  logic         ptd_n    = 1'b0;
  logic         bode     = 1'b0;
  logic         dog      = 1'b0;
  logic         wake     = 1'b0;
  logic [7:0]   flags    = 8'h05;
  logic         irqen    = 1'b0;
  logic         slp      = 1'b0;
  logic [12:0]  pc       = 13'h0000;
  logic         core_rst;
  logic         pcl;
  logic [12:0]  pcv;
  logic [7:0]   st;
  logic [7:0]   opt;
  logic [7:0]   pdir;
  logic [7:0]   ictl;
  logic         irq;
  logic [31:0]  q;
  logic         e;
  int           checks   = 0;
  int           failures = 0;

  rct_reset_cause #(.POWERUP_TIMER_CYCLES(PW), .OST_PERIODS(OS)) dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .apb_req_i(req), .apb_rsp_o(rsp),
    .master_clear_pin_n_i(clr_n), .brownout_det_i(bod), .osc_clk_i(osc),
    .osc_mode_i(mode), .powerup_timer_disable_n_i(ptd_n), .brownout_detect_enable_i(bode),
    .watchdog_timeout_i(dog), .irq_wake_i(wake), .irq_flags_i(flags),
    .global_irq_enable_i(irqen), .sleep_enter_i(slp), .pc_i(pc), .core_reset_o(core_rst),
    .pc_load_o(pcl), .pc_value_o(pcv), .status_o(st), .option_o(opt),
    .port_dir_o(pdir), .irq_ctrl_o(ictl), .irq_o(irq)
  );

  // Core clock, and an oscillator pin at a tenth of its rate, changed on core edges
  initial
    forever #2 clk = ~clk;
  initial
    forever
    begin
      repeat (5) @(posedge clk);
      osc <= ~osc;
    end

  // One APB transfer; read data lands in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, d};
    do
      @(posedge clk);
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '{1'b0, 1'b0, w, a, d};
    @(posedge clk);
  endtask

  // Counts cycles until the pc load pulse ends the hold
  task automatic hold(output int h);
    h = 0;
    @(posedge clk);
    while (pcl !== 1'b1)
    begin
      @(posedge clk);
      h++;
    end
  endtask

  task automatic por(input logic [1:0] m, input logic tn, input logic be, output int h);
    mode <= m;
    ptd_n <= tn;
    bode <= be;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    hold(h);
  endtask

  // Sleep, then wake by watchdog or interrupt
  task automatic nap(input logic by_dog, input logic ie, input logic [12:0] p, output int h);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    irqen <= ie;
    pc <= p;
    @(posedge clk);
    wake <= !by_dog;
    dog <= by_dog;
    @(posedge clk);
    wake <= 1'b0;
    dog <= 1'b0;
    hold(h);
  endtask

  task automatic t_por_xtal();
    int h;
    por(2'b01, 1'b0, 1'b0, h);
    `CHK(h >= PW + (OS - 1) * 10, 1'b1)
    `CHK(pcv, 13'h0000)
    `CHK(st, 8'h18)
    `CHK({opt, pdir, ictl}, 24'hffff00)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q[1], 1'b0)
    apb(1'b0, 8'h24, 32'h0);
    `CHK({e, q}, 33'h100000000)
  endtask

  task automatic t_sw_clear();
    int h;
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h00000003)
    apb(1'b1, 8'h04, 32'h000000ff);
    apb(1'b1, 8'h08, 32'h0);
    clr_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({core_rst, st}, 9'h11f)
    clr_n <= 1'b1;
    hold(h);
    `CHK({pcv, opt}, 21'h000ff)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q[1:0], 2'b11)
  endtask

  // Watchdog reset, then raise, mask and clear its event interrupt
  task automatic t_dog_irq();
    int h;
    dog <= 1'b1;
    @(posedge clk);
    dog <= 1'b0;
    hold(h);
    `CHK(st, 8'h0f)
    `CHK(pcv, 13'h0000)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(q[3], 1'b1)
    apb(1'b1, 8'h18, 32'h08);
    @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h18, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h18, 32'h08);
    apb(1'b1, 8'h14, 32'h3f);
    @(posedge clk);
    `CHK(irq, 1'b0)
    // Crystal mode wake waits for the start-up count only
    nap(1'b0, 1'b0, 13'h0010, h);
    `CHK(h >= (OS - 1) * 10, 1'b1)
    `CHK(pcv, 13'h0011)
    `CHK(st[4:3], 2'b10)
  endtask

  task automatic t_wakes();
    int h;
    por(2'b11, 1'b1, 1'b0, h);
    `CHK(h < 8, 1'b1)
    apb(1'b1, 8'h10, 32'h80);
    nap(1'b0, 1'b1, 13'h0123, h);
    `CHK(pcv, 13'h0004)
    `CHK(st[4:3], 2'b10)
    `CHK(ictl, 8'h85)
    nap(1'b0, 1'b0, 13'h1fff, h);
    `CHK(pcv, 13'h0000)
    nap(1'b1, 1'b0, 13'h0200, h);
    `CHK(pcv, 13'h0201)
    `CHK(st[4:3], 2'b00)
    // Master clear while asleep: top bits cleared, time-out set, power-down clear
    apb(1'b1, 8'h04, 32'h000000e7);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    clr_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({core_rst, st}, 9'h117)
    clr_n <= 1'b1;
    hold(h);
    `CHK(pcv, 13'h0000)
  endtask

  task automatic t_brownout();
    int h;
    por(2'b11, 1'b1, 1'b1, h);
    `CHK(h >= PW, 1'b1)
    apb(1'b1, 8'h00, 32'h3);
    bod <= 1'b1;
    repeat (6) @(posedge clk);
    bod <= 1'b0;
    hold(h);
    `CHK(h >= PW, 1'b1)
    `CHK({st[4:3], pcv}, 15'h6000)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q[1:0], 2'b10)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    t_por_xtal();
    t_sw_clear();
    t_dog_irq();
    t_wakes();
    t_brownout();
    tally_and_finish();
  end
endmodule
